// ### rtl/cam_params.svh
/*
  Constants of the counter array mode block: APB offsets, mode bit
  positions, reset values.
  Assumes inclusion by bare name from the design, the checker and the bench.
*/
`ifndef CAM_PARAMS_SVH
`define CAM_PARAMS_SVH

// ------------------------------------------------------------
// Register offsets (byte addresses)
// ------------------------------------------------------------
`define CAM_OFF_CTRL 12'h000
`define CAM_OFF_CNT 12'h004
`define CAM_OFF_MODE0 12'h010
`define CAM_OFF_CMP0 12'h030
`define CAM_OFF_IRQ_STAT 12'h050
`define CAM_OFF_IRQ_MASK 12'h054
`define CAM_MOD_STRIDE 12'h004

// ------------------------------------------------------------
// Mode register bit positions
// ------------------------------------------------------------
`define CAM_B_IRQEN 0
`define CAM_B_PWM 1
`define CAM_B_TOG 2
`define CAM_B_MAT 3
`define CAM_B_CAPN 4
`define CAM_B_CAPP 5
`define CAM_B_ECOM 6

// Control register bit positions
`define CAM_B_RUN 6
`define CAM_B_OVF 7

// ------------------------------------------------------------
// Reset values and widths
// ------------------------------------------------------------
`define CAM_RST_BYTE 8'h00
`define CAM_RST_WORD 16'h0000
`define CAM_WORD_MAX 16'hFFFF
`define CAM_BYTE_MAX 8'hFF
`define CAM_MODE_MASK 8'h7F
`define CAM_ZERO32 32'h00000000

`endif

// ### rtl/cam_pkg.sv
/*
  Types of the counter array mode block.
  Holds its own literal values; cam_params.svh is not included.
*/
package cam_pkg;
  // Decoded module function, one-hot
  typedef enum logic [6:0] {
    CAM_NOP = 7'h01,
    CAM_CAP = 7'h02,
    CAM_TMR = 7'h04,
    CAM_HSO = 7'h08,
    CAM_PWM = 7'h10,
    CAM_WDT = 7'h20,
    CAM_BAD = 7'h40
  } cam_mode_t;
endpackage

// ### rtl/cam_core.sv
/*
  Counter array: control flags, per-module mode decode, capture,
  compare, high-speed toggle and 8-bit PWM, reached over APB.
  Assumes module pins synchronous to clock; one clock domain.
*/
`timescale 1ns/1ps
`include "cam_params.svh"

// How it works
// RULE1 - Mode rising-only: capture counter on pin rise
// RULE2 - Mode falling-only: capture counter on pin fall
// RULE3 - Both capture bits: capture on either edge
// RULE4 - Compare, match, toggle set: high-speed output
// RULE5 - Match or capture sets flag; software clears
// RULE6 - Capture copies counter bytes into compare bytes
// RULE7 - Interrupt only when flag and enable set; irq itself follows status and mask, not the flag or irq enable bit
// RULE8 - High-speed output inverts pin on match
// RULE9 - PWM low below compare; reload on wrap
module cam_core #(
  parameter int NMOD = 5
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NMOD-1:0] module_io_pin_in,
  output logic [NMOD-1:0] module_io_pin_out,
  output logic [NMOD-1:0] module_io_pin_oe,
  output logic [NMOD-1:0] module_irq,
  output logic irq
);

  // ------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------
  logic [7:0] array_control_reg;
  logic [7:0] module_mode_reg [NMOD];
  logic [7:0] module_compare_low [NMOD];
  logic [7:0] module_compare_high [NMOD];
  logic [7:0] counter_low_byte;
  logic [7:0] counter_high_byte;
  logic [NMOD-1:0] pin_reg;
  logic [NMOD-1:0] out_reg;
  logic [NMOD:0] stat_reg;
  logic [NMOD:0] mask_reg;
  logic [31:0] prdata_reg;
  cam_pkg::cam_mode_t mode [NMOD];
  logic [NMOD-1:0] cap_hit;
  logic [NMOD-1:0] cmp_hit;
  logic [NMOD-1:0] event_hit;
  logic wr;
  logic rd;
  logic hit_any;
  logic wrap;
  logic counter_run_bit;
  logic [15:0] count;
  logic [NMOD:0] stat_evt;
  logic [5:0] mode_key [NMOD];
  logic ovf_hit;

  // ------------------------------------------------------------
  // APB decode
  // ------------------------------------------------------------
  // Zero-wait slave: every access ends in its first access cycle
  assign pready = 1'b1;
  assign wr = psel && penable && pwrite;
  assign rd = psel && penable && !pwrite;
  assign counter_run_bit = array_control_reg[`CAM_B_RUN];
  assign count = {counter_high_byte, counter_low_byte};
  assign wrap = counter_run_bit && (counter_low_byte == `CAM_BYTE_MAX);
  // Overflow: full count while running, wraps to zero next edge
  assign ovf_hit = counter_run_bit && (count == `CAM_WORD_MAX);

  // Address decode: hit on any mapped word
  always_comb begin
    hit_any = (paddr == `CAM_OFF_CTRL) || (paddr == `CAM_OFF_CNT) ||
              (paddr == `CAM_OFF_IRQ_STAT) || (paddr == `CAM_OFF_IRQ_MASK);
    for (int i = 0; i < NMOD; i++) begin
      if (paddr == `CAM_OFF_MODE0 + 12'(i) * `CAM_MOD_STRIDE) begin
        hit_any = 1'b1;
      end
      if (paddr == `CAM_OFF_CMP0 + 12'(i) * `CAM_MOD_STRIDE) begin
        hit_any = 1'b1;
      end
    end
  end
  assign pslverr = psel && penable && !hit_any;

  // ------------------------------------------------------------
  // Mode decode and per-module events
  // ------------------------------------------------------------
  // Function bits of each mode byte; irq enable takes no part
  always_comb begin
    for (int i = 0; i < NMOD; i++) begin
      mode_key[i] = {module_mode_reg[i][`CAM_B_ECOM], module_mode_reg[i][`CAM_B_CAPP],
                     module_mode_reg[i][`CAM_B_CAPN], module_mode_reg[i][`CAM_B_MAT],
                     module_mode_reg[i][`CAM_B_TOG], module_mode_reg[i][`CAM_B_PWM]};
    end
  end

  // Capture modes ignore compare and irq enable bits
  // Watchdog is decoded for the last module only and raises no reset here
  always_comb begin
    for (int i = 0; i < NMOD; i++) begin
      case (mode_key[i])
        6'h00: mode[i] = cam_pkg::CAM_NOP;
        6'h10, 6'h30: mode[i] = cam_pkg::CAM_CAP; // see RULE1
        6'h08, 6'h28: mode[i] = cam_pkg::CAM_CAP; // see RULE2
        6'h18, 6'h38: mode[i] = cam_pkg::CAM_CAP; // see RULE3
        6'h24: mode[i] = (i == NMOD - 1) ? cam_pkg::CAM_WDT : cam_pkg::CAM_TMR;
        6'h26: mode[i] = cam_pkg::CAM_HSO; // see RULE4
        6'h21: mode[i] = cam_pkg::CAM_PWM;
        default: mode[i] = cam_pkg::CAM_BAD;
      endcase
    end
  end

  // Edge qualify per enable; compare needs a running counter
  always_comb begin
    for (int i = 0; i < NMOD; i++) begin
      cap_hit[i] = (mode[i] == cam_pkg::CAM_CAP) &&
        ((module_mode_reg[i][`CAM_B_CAPP] && module_io_pin_in[i] && !pin_reg[i]) ||
         (module_mode_reg[i][`CAM_B_CAPN] && !module_io_pin_in[i] && pin_reg[i]));
      cmp_hit[i] = counter_run_bit && module_mode_reg[i][`CAM_B_ECOM] &&
        module_mode_reg[i][`CAM_B_MAT] &&
        (count == {module_compare_high[i], module_compare_low[i]});
      event_hit[i] = cap_hit[i] || cmp_hit[i];
    end
  end

  // Pin history for edge detection
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pin_reg <= '0;
    end else begin
      pin_reg <= module_io_pin_in;
    end
  end

  // ------------------------------------------------------------
  // Shared counter
  // ------------------------------------------------------------
  // Software load beats counting; no prescaler, one step per clock
  // A load while running costs that cycle's increment
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      counter_low_byte <= `CAM_RST_BYTE;
      counter_high_byte <= `CAM_RST_BYTE;
    end else if (wr && paddr == `CAM_OFF_CNT) begin
      counter_low_byte <= pwdata[7:0];
      counter_high_byte <= pwdata[15:8];
    end else if (counter_run_bit) begin
      {counter_high_byte, counter_low_byte} <= count + 16'h0001;
    end
  end

  // ------------------------------------------------------------
  // Control register: run bit, overflow and module flags
  // ------------------------------------------------------------
  // Hardware set wins over a software clear in the same cycle
  // A software write stores every bit, flags included
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      array_control_reg <= `CAM_RST_BYTE;
    end else begin
      if (wr && paddr == `CAM_OFF_CTRL) begin
        array_control_reg <= pwdata[7:0];
      end
      if (ovf_hit) begin
        array_control_reg[`CAM_B_OVF] <= 1'b1;
      end
      for (int i = 0; i < NMOD; i++) begin
        if (event_hit[i]) begin
          array_control_reg[i] <= 1'b1; // see RULE5
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Mode and compare registers
  // ------------------------------------------------------------
  // Bit 7 is not stored, so it reads back as zero
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < NMOD; i++) begin
        module_mode_reg[i] <= `CAM_RST_BYTE;
      end
    end else if (wr) begin
      for (int i = 0; i < NMOD; i++) begin
        if (paddr == `CAM_OFF_MODE0 + 12'(i) * `CAM_MOD_STRIDE) begin
          module_mode_reg[i] <= pwdata[7:0] & `CAM_MODE_MASK;
        end
      end
    end
  end

  // Capture load beats a software write; PWM reload on low wrap
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < NMOD; i++) begin
        module_compare_low[i] <= `CAM_RST_BYTE;
        module_compare_high[i] <= `CAM_RST_BYTE;
      end
    end else begin
      for (int i = 0; i < NMOD; i++) begin
        if (cap_hit[i]) begin
          module_compare_low[i] <= counter_low_byte; // see RULE6
          module_compare_high[i] <= counter_high_byte;
        end else if (wr && paddr == `CAM_OFF_CMP0 + 12'(i) * `CAM_MOD_STRIDE) begin
          module_compare_low[i] <= pwdata[7:0];
          module_compare_high[i] <= pwdata[15:8];
        end else if (mode[i] == cam_pkg::CAM_PWM && wrap) begin
          module_compare_low[i] <= module_compare_high[i]; // see RULE9
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Module pin outputs
  // ------------------------------------------------------------
  // Pin driven only in toggle and PWM modes
  // Leaving a driving mode releases the pin one edge later
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      out_reg <= '0;
      module_io_pin_oe <= '0;
    end else begin
      for (int i = 0; i < NMOD; i++) begin
        module_io_pin_oe[i] <= (mode[i] == cam_pkg::CAM_HSO) ||
                               (mode[i] == cam_pkg::CAM_PWM);
        if (mode[i] == cam_pkg::CAM_HSO && cmp_hit[i]) begin
          out_reg[i] <= !out_reg[i]; // see RULE8
        end else if (mode[i] == cam_pkg::CAM_PWM) begin
          out_reg[i] <= !(counter_low_byte < module_compare_low[i]); // see RULE9
        end
      end
    end
  end
  assign module_io_pin_out = out_reg;

  // ------------------------------------------------------------
  // Interrupts
  // ------------------------------------------------------------
  // Per-module request follows flag and enable as levels
  always_comb begin
    for (int i = 0; i < NMOD; i++) begin
      module_irq[i] = array_control_reg[i] &&
                      module_mode_reg[i][`CAM_B_IRQEN]; // see RULE7
    end
  end
  // Status and mask share one layout: module bits, then overflow
  assign stat_evt = {ovf_hit, event_hit};

  // Sticky status, read clears; new event wins over the clear
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      stat_reg <= '0;
      mask_reg <= '0;
    end else begin
      if (rd && paddr == `CAM_OFF_IRQ_STAT) begin
        stat_reg <= stat_evt;
      end else begin
        stat_reg <= stat_reg | stat_evt;
      end
      if (wr && paddr == `CAM_OFF_IRQ_MASK) begin
        mask_reg <= pwdata[NMOD:0];
      end
    end
  end
  assign irq = |(stat_reg & mask_reg);

  // ------------------------------------------------------------
  // Read data
  // ------------------------------------------------------------
  // Registered in the setup cycle so data stands in access
  // Reads have no side effect but the status clear
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      prdata_reg <= `CAM_ZERO32;
    end else if (psel && !penable && !pwrite) begin
      prdata_reg <= `CAM_ZERO32;
      if (paddr == `CAM_OFF_CTRL) prdata_reg[7:0] <= array_control_reg;
      if (paddr == `CAM_OFF_CNT) prdata_reg[15:0] <= count;
      if (paddr == `CAM_OFF_IRQ_STAT) prdata_reg[NMOD:0] <= stat_reg | stat_evt;
      if (paddr == `CAM_OFF_IRQ_MASK) prdata_reg[NMOD:0] <= mask_reg;
      for (int i = 0; i < NMOD; i++) begin
        if (paddr == `CAM_OFF_MODE0 + 12'(i) * `CAM_MOD_STRIDE) begin
          prdata_reg[7:0] <= module_mode_reg[i];
        end
        if (paddr == `CAM_OFF_CMP0 + 12'(i) * `CAM_MOD_STRIDE) begin
          prdata_reg[15:0] <= {module_compare_high[i], module_compare_low[i]};
        end
      end
    end
  end
  assign prdata = prdata_reg;

endmodule

// ### sim/cam_core_asserts.sv
/*
  Checker of the counter array block, bound to cam_core.
  Assumes zero-wait APB traffic and synchronous pins; watches module 0.
*/
`timescale 1ns/1ps
`include "cam_params.svh"
module cam_core_asserts #(
  parameter int NMOD = 5
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [NMOD-1:0] module_io_pin_in,
  input wire logic [NMOD-1:0] module_io_pin_out,
  input wire logic [NMOD-1:0] module_io_pin_oe,
  input wire logic [NMOD-1:0] module_irq,
  input wire logic irq
);
  logic [6:0] mode0_reg;
  // Shadow of module 0 mode, so pin rules know which function is live
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      mode0_reg <= 7'h00;
    end else if (psel && penable && pwrite && paddr == `CAM_OFF_MODE0) begin
      mode0_reg <= pwdata[6:0];
    end
  end
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);
  sequence s_access;
    psel && penable;
  endsequence
  property p_ready;
    s_access |-> pready;
  endproperty
  property p_unmapped;
    s_access ##0 paddr > `CAM_OFF_IRQ_MASK |-> pslverr && (pwrite || prdata == 32'h00000000);
  endproperty
  property p_rise;
    mode0_reg == 7'h21 && $rose(module_io_pin_in[0]) |-> ##[1:2] module_irq[0];
  endproperty
  property p_fall;
    mode0_reg == 7'h11 && $fell(module_io_pin_in[0]) |-> ##[1:2] module_irq[0];
  endproperty
  property p_both;
    mode0_reg == 7'h31 && $changed(module_io_pin_in[0]) |-> ##[1:2] module_irq[0];
  endproperty
  property p_sticky;
    module_irq[0] && !(psel && pwrite) |=> module_irq[0];
  endproperty
  property p_gate;
    module_irq[0] |-> mode0_reg[0];
  endproperty
  property p_hso_oe;
    mode0_reg[6:1] == 6'h26 [*3] |-> module_io_pin_oe[0];
  endproperty
  property p_toggle;
    mode0_reg == 7'h4D && $changed(module_io_pin_out[0]) |-> ##[0:1] module_irq[0];
  endproperty
  property p_pwm_oe;
    mode0_reg == 7'h42 [*3] |-> module_io_pin_oe[0];
  endproperty
  a_ready: assert property (p_ready) else $error("pready low in access");
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
  a_rise: assert property (p_rise) else $error("rise capture missed");
  a_fall: assert property (p_fall) else $error("fall capture missed");
  a_both: assert property (p_both) else $error("edge capture missed");
  a_sticky: assert property (p_sticky) else $error("flag dropped alone");
  a_gate: assert property (p_gate) else $error("irq without enable");
  a_hso_oe: assert property (p_hso_oe) else $error("hso pin not driven");
  a_toggle: assert property (p_toggle) else $error("toggle without match");
  a_pwm_oe: assert property (p_pwm_oe) else $error("pwm pin not driven");
endmodule
bind cam_core cam_core_asserts #(.NMOD(NMOD)) i_cam_core_asserts (.clock(clock),
  .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .module_io_pin_in(module_io_pin_in), .module_io_pin_out(module_io_pin_out),
  .module_io_pin_oe(module_io_pin_oe), .module_irq(module_irq), .irq(irq));

// ### sim/cam_pins_model.sv
/*
  Far side of the module pins: resolves each pin wire.
  Assumes the bench sets the level driven from outside.
*/
`timescale 1ns/1ps
module cam_pins_model #(
  parameter int NMOD = 5
) (
  input wire logic [NMOD-1:0] ext_level,
  input wire logic [NMOD-1:0] pin_out,
  input wire logic [NMOD-1:0] pin_oe,
  output logic [NMOD-1:0] pin_in
);
  // Block wins where it drives, so no fight on a shared wire
  always_comb begin
    pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
  end
endmodule

// ### sim/counter_array_module_modes_tb.sv
/*
  Self-checking bench of the counter array block over APB.
  Assumes cam_core, its checker and the pin model are compiled.
*/
`timescale 1ns/1ps
`include "cam_params.svh"
module counter_array_module_modes_tb;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [4:0] ext = 5'h00;
  logic [31:0] prdata, q;
  logic pready, pslverr, irq, err_q, hit;
  logic [4:0] pin_in, pin_out, pin_oe, mirq;
  logic [6:0] capm [3] = '{7'h21, 7'h11, 7'h31};
  int err_total = 0;
  int compares = 0;
  initial begin
    forever #20 clock = ~clock;
  end
  cam_core i_cam_core (.clock(clock), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .module_io_pin_in(pin_in), .module_io_pin_out(pin_out),
    .module_io_pin_oe(pin_oe), .module_irq(mirq), .irq(irq));
  cam_pins_model i_cam_pins_model (.ext_level(ext), .pin_out(pin_out),
    .pin_oe(pin_oe), .pin_in(pin_in));
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  // One APB transfer; holds everything until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    // No cycle count assumed; the hang guard ends a stuck wait
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    q = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input string n, input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h00000000);
    chk(n, e, q);
  endtask
  // Pin levels move a few cycles apart so each edge is seen alone
  task automatic pin(input logic v);
    ext[0] <= v;
    repeat (4) @(posedge clock);
    @(negedge clock);
  endtask
  task automatic outchk(input string n, input logic e);
    repeat (3) @(posedge clock);
    @(negedge clock);
    chk(n, 32'(e), 32'(pin_out[0]));
  endtask
  task automatic close_out;
    $display("Counts: %0d compares, %0d mismatches", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Hang guard of 20000 cycles, far beyond the few hundred cycles the tests need
  initial begin
    #(40 * 20000);
    err_total++;
    close_out;
  end
  // ------------------------------------------------------------
  // Test sequence
  // ------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clock);
    nrst <= 1'b1;
    rd("ctrl", `CAM_OFF_CTRL, 32'h00000000);
    rd("mode0", `CAM_OFF_MODE0, 32'h00000000);
    apb(1'b0, 12'h0FC, 32'h00000000);
    chk("slverr", 32'h00000001, 32'(err_q));
    wr(`CAM_OFF_IRQ_MASK, 32'h00000001);
    $display("test reset done");
    // Counter held still so the captured value is exact
    for (int i = 0; i < 3; i++) begin
      wr(`CAM_OFF_CNT, 32'h00001230 + i);
      wr(`CAM_OFF_MODE0, 32'(capm[i]));
      for (int v = 1; v >= 0; v--) begin
        pin(v[0]);
        hit = v[0] ? capm[i][5] : capm[i][4];
        chk("module_irq", 32'(hit), 32'(mirq[0]));
        chk("irq", 32'(hit), 32'(irq));
        rd("stat", `CAM_OFF_IRQ_STAT, 32'(hit));
        @(negedge clock);
        chk("irq clear", 32'h00000000, 32'(irq));
        rd("flag", `CAM_OFF_CTRL, 32'(hit));
        wr(`CAM_OFF_CTRL, 32'h00000000);
      end
      rd("capture", `CAM_OFF_CMP0, 32'h00001230 + i);
    end
    $display("test capture done");
    wr(`CAM_OFF_CMP0, 32'h00000100);
    wr(`CAM_OFF_CNT, 32'h000000FC);
    wr(`CAM_OFF_MODE0, 32'h0000004D);
    wr(`CAM_OFF_CTRL, 32'h00000040);
    repeat (12) @(posedge clock);
    // Flag read while running; a control write would overwrite it
    rd("hso flag", `CAM_OFF_CTRL, 32'h00000041);
    wr(`CAM_OFF_CTRL, 32'h00000000);
    @(negedge clock);
    chk("hso oe", 32'h00000001, 32'(pin_oe[0]));
    chk("hso out", 32'h00000001, 32'(pin_out[0]));
    $display("test hso done");
    // Low byte 80 live, 20 waiting for the wrap
    wr(`CAM_OFF_MODE0, 32'h00000042);
    wr(`CAM_OFF_CMP0, 32'h00002080);
    wr(`CAM_OFF_CNT, 32'h00000010);
    outchk("pwm low", 1'b0);
    wr(`CAM_OFF_CNT, 32'h00000090);
    outchk("pwm high", 1'b1);
    wr(`CAM_OFF_CNT, 32'h000000FE);
    wr(`CAM_OFF_CTRL, 32'h00000040);
    repeat (4) @(posedge clock);
    wr(`CAM_OFF_CTRL, 32'h00000000);
    wr(`CAM_OFF_CNT, 32'h00000030);
    outchk("pwm reload", 1'b1);
    $display("test pwm done");
    close_out;
  end
endmodule
